// file: lane_fifo_status_sync_mask.sv
`timescale 1ns/1ps
// Function
// R1 - three-bit source field bits 2:0 of lanes 6/7 crossbar picks lane 6 input
// R2 - source code n routes physical serial input n to the logical lane
// R3 - read-only byte, bit x is full flag of input x receive FIFO
// R4 - read-only byte, bit x is empty flag of input x FIFO; resets zero
// R5 - mask bit 3 set: deframer 1 multiframe loss drives sync request 1 low
// R6 - mask bit 2 set: deframer 0 multiframe loss drives sync request 0 low
// R7 - mask bit 1 set: deframer 1 frame loss drives sync request 1 low
// R8 - mask bit 0 set: deframer 0 frame loss drives sync request 0 low
// R9 - all four mask bits reset zero; bits 7 to 4 read zero
module lane_fifo_status_sync_mask
    import lane_sync_pkg::*;
#(
    parameter int LANE_W = 8
) (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             reset,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [lane_sync_pkg::ADDR_W-1:0] paddr,
    input  wire logic [lane_sync_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [lane_sync_pkg::DATA_W-1:0] prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // physical lane data and receive fifo flags
    input  wire logic [lane_sync_pkg::LANES*LANE_W-1:0] physical_serial_input,
    input  wire logic [lane_sync_pkg::LANES-1:0]  lane_fifo_full,
    input  wire logic [lane_sync_pkg::LANES-1:0]  lane_fifo_empty,
    // alignment loss from deframers (same clock)
    input  wire logic                             deframer0_frame_loss,
    input  wire logic                             deframer1_frame_loss,
    input  wire logic                             deframer0_multiframe_loss,
    input  wire logic                             deframer1_multiframe_loss,
    // outputs
    output logic      [LANE_W-1:0]                logical_lane6,
    output logic                                  sync_request_out0_n,
    output logic                                  sync_request_out1_n,
    output logic                                  irq
);
    import lane_sync_pkg::*;

    // byte address decode: word aligned, register at four times the index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
        hit = (a == {idx, 2'h0});
    endfunction : hit

    logic [SEL_W-1:0]  logical_lane6_source_select_q;
    logic [SEL_W-1:0]  logical_lane7_source_select_q;
    logic [MASK_W-1:0] masks_q;
    logic [IRQ_W-1:0]  irq_status_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [LANES-1:0]  full_sync;
    logic [LANES-1:0]  empty_sync;
    logic [LANE_W-1:0] lane6_sel;
    logic              access;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic [IRQ_W-1:0]  events;
    logic              loss0;
    logic              loss1;
    logic              setup;
    logic              rd_setup;
    logic              sel_xbar;
    logic              sel_full;
    logic              sel_empty;
    logic              sel_masks;
    logic              sel_istat;
    logic              sel_imask;
    logic              wr_xbar;
    logic              wr_masks;
    logic              wr_imask;
    logic              rd_istat;
    logic [SEL_W-1:0]  lane6_wdata;
    logic [SEL_W-1:0]  lane7_wdata;
    logic [MASK_W-1:0] masks_wdata;
    logic [IRQ_W-1:0]  imask_wdata;
    logic [BYTE_W-1:0] rd_byte;
    logic [IRQ_W-1:0]  irq_pending;
    logic [LINKS-1:0]  frame_en;
    logic [LINKS-1:0]  multiframe_en;
    logic [LINKS-1:0]  frame_loss;
    logic [LINKS-1:0]  multiframe_loss;
    logic [LINKS-1:0]  link_loss;

    // fifo flags come from the lane clock domain
    pin_sync3 #(
        .WIDTH (2*LANES)
    ) u_flag_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({lane_fifo_empty, lane_fifo_full}),
        .dout  ({empty_sync, full_sync})
    );

    // logical lane 6 crossbar
    lane_mux8 #(
        .LANES (LANES),
        .SEL_W (SEL_W),
        .W     (LANE_W)
    ) u_lane6_mux (
        .lanes    (physical_serial_input),
        .sel      (logical_lane6_source_select_q),
        .lane_out (lane6_sel)
    );

    // bus phase decode
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign wr       = access && pwrite;
    assign rd       = access && !pwrite;
    assign rd_setup = setup && !pwrite;

    // one select per register word
    assign sel_xbar  = hit(paddr, IDX_XBAR_LN_6_7);
    assign sel_full  = hit(paddr, IDX_FIFO_FULL);
    assign sel_empty = hit(paddr, IDX_FIFO_EMPTY);
    assign sel_masks = hit(paddr, IDX_SYNC_MASKS);
    assign sel_istat = hit(paddr, IDX_IRQ_STATUS);
    assign sel_imask = hit(paddr, IDX_IRQ_MASK);
    assign mapped    = sel_xbar || sel_full || sel_empty
                    || sel_masks || sel_istat || sel_imask;

    // write strobes; only the low byte lane carries register data
    assign wr_xbar  = wr && pstrb[0] && sel_xbar;
    assign wr_masks = wr && pstrb[0] && sel_masks;
    assign wr_imask = wr && pstrb[0] && sel_imask;
    // status read in its access cycle, clears what it returned
    assign rd_istat = rd && sel_istat;

    // register fields of the write word
    assign lane6_wdata = pwdata[LANE6_LSB +: SEL_W];
    assign lane7_wdata = pwdata[LANE7_LSB +: SEL_W];
    assign masks_wdata = pwdata[MASK_W-1:0];
    assign imask_wdata = pwdata[IRQ_W-1:0];

    // loss events in status-bit order
    assign events = {deframer1_multiframe_loss, deframer0_multiframe_loss,
                     deframer1_frame_loss, deframer0_frame_loss};

    // enable bits and loss inputs gathered per link
    assign frame_en        = {masks_q[FRAME_EN1_BIT], masks_q[FRAME_EN0_BIT]};
    assign multiframe_en   = {masks_q[MF_EN1_BIT], masks_q[MF_EN0_BIT]};
    assign frame_loss      = {deframer1_frame_loss, deframer0_frame_loss};
    assign multiframe_loss = {deframer1_multiframe_loss, deframer0_multiframe_loss};

    // masked loss per link; a cleared enable leaves the output alone
    genvar l;
    generate
        for (l = 0; l < LINKS; l++) begin : g_link
            assign link_loss[l] = (frame_en[l] && frame_loss[l])             // R7 R8
                               || (multiframe_en[l] && multiframe_loss[l]);  // R5 R6
        end
    endgenerate

    // loss per sync output
    assign loss0 = link_loss[0];  // R6 R8
    assign loss1 = link_loss[1];  // R5 R7

    // crossbar source registers
    always_ff @(posedge clk) begin
        if (reset) begin
            logical_lane6_source_select_q <= LANE6_RESET;
            logical_lane7_source_select_q <= LANE7_RESET;
        end else if (wr_xbar) begin
            logical_lane6_source_select_q <= lane6_wdata;  // R1
            logical_lane7_source_select_q <= lane7_wdata;
        end
    end

    // sync-request loss masks, reserved upper bits not stored
    always_ff @(posedge clk) begin
        if (reset) begin
            masks_q <= MASKS_RESET;  // R9
        end else if (wr_masks) begin
            masks_q <= masks_wdata;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_mask_q <= '0;
        end else if (wr_imask) begin
            irq_mask_q <= imask_wdata;
        end
    end

    // sticky status per bit; a read clears only the bits it returned, so an
    // event landing between setup and access is not lost; new event wins
    genvar b;
    generate
        for (b = 0; b < IRQ_W; b++) begin : g_istat
            always_ff @(posedge clk) begin
                if (reset) begin
                    irq_status_q[b] <= 1'h0;
                end else if (events[b]) begin
                    irq_status_q[b] <= 1'h1;
                end else if (rd_istat && prdata[b]) begin
                    irq_status_q[b] <= 1'h0;
                end
            end
        end
    endgenerate

    // unmasked pending status
    assign irq_pending = irq_status_q & irq_mask_q;

    // read byte mux; reserved bits read zero
    always_comb begin
        rd_byte = '0;
        if (sel_xbar) begin
            rd_byte = {2'h0, logical_lane7_source_select_q, logical_lane6_source_select_q};
        end else if (sel_full) begin
            rd_byte = full_sync;                   // R3
        end else if (sel_empty) begin
            rd_byte = empty_sync;                  // R4
        end else if (sel_masks) begin
            rd_byte = BYTE_W'(masks_q);            // R9
        end else if (sel_istat) begin
            rd_byte = BYTE_W'(irq_status_q);
        end else if (sel_imask) begin
            rd_byte = BYTE_W'(irq_mask_q);
        end
    end

    // apb answer, zero wait states, unmapped gives error
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'h0;
            pslverr <= 1'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= ZERO_WORD;
            if (rd_setup) begin
                prdata[BYTE_W-1:0] <= rd_byte;
            end
        end
    end

    // sync outputs low on enabled loss, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_request_out0_n <= 1'b1;
            sync_request_out1_n <= 1'b1;
        end else begin
            sync_request_out0_n <= !loss0;  // R6 R8
            sync_request_out1_n <= !loss1;  // R5 R7
        end
    end

    // registered lane 6 and interrupt
    always_ff @(posedge clk) begin
        if (reset) begin
            logical_lane6 <= '0;
            irq           <= 1'b0;
        end else begin
            logical_lane6 <= lane6_sel;  // R2
            irq           <= |irq_pending;
        end
    end
endmodule : lane_fifo_status_sync_mask

// file: lane_sync_pkg.sv
package lane_sync_pkg;
    // register indices; the byte address is four times the index
    localparam logic [11:0] IDX_XBAR_LN_6_7   = 12'h30B;
    localparam logic [11:0] IDX_FIFO_FULL     = 12'h30C;
    localparam logic [11:0] IDX_FIFO_EMPTY    = 12'h30D;
    localparam logic [11:0] IDX_SYNC_MASKS    = 12'h311;
    localparam logic [11:0] IDX_IRQ_STATUS    = 12'h320;
    localparam logic [11:0] IDX_IRQ_MASK      = 12'h321;
    localparam int          ADDR_W            = 14;
    localparam int          DATA_W            = 32;
    localparam int          LANES             = 8;
    localparam int          SEL_W             = 3;
    localparam int          BYTE_W            = 8;
    localparam int          LINKS             = 2;
    localparam int          MASK_W            = 4;
    // crossbar field layout
    localparam int          LANE6_LSB         = 0;
    localparam int          LANE7_LSB         = 3;
    localparam logic [2:0]  LANE6_RESET       = 3'h6;
    localparam logic [2:0]  LANE7_RESET       = 3'h7;
    // mask register bit positions
    localparam int          FRAME_EN0_BIT     = 0;
    localparam int          FRAME_EN1_BIT     = 1;
    localparam int          MF_EN0_BIT        = 2;
    localparam int          MF_EN1_BIT        = 3;
    localparam logic [3:0]  MASKS_RESET       = 4'h0;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    // interrupt status bits
    localparam int          IRQ_FRAME0_BIT    = 0;
    localparam int          IRQ_FRAME1_BIT    = 1;
    localparam int          IRQ_MF0_BIT       = 2;
    localparam int          IRQ_MF1_BIT       = 3;
    localparam int          IRQ_W             = 4;
    localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
endpackage : lane_sync_pkg

// file: pin_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // shift chain
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a bit only when the last two stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_agree
            always_ff @(posedge clk) begin
                if (reset) begin
                    dout[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync3

// file: lane_mux8.sv
`timescale 1ns/1ps
// selects one physical lane word by a binary code
module lane_mux8 #(
    parameter int LANES = 8,
    parameter int SEL_W = 3,
    parameter int W     = 8
) (
    // lanes in
    input  wire logic [LANES*W-1:0] lanes,
    input  wire logic [SEL_W-1:0]   sel,
    // selected lane out
    output logic      [W-1:0]       lane_out
);
    // index equals code
    assign lane_out = lanes[sel*W +: W];  // R2
endmodule : lane_mux8

// file: serial_lane_source.sv
`timescale 1ns/1ps
// stand-in transmitter: lane x word is {count, x}, new every cycle
module serial_lane_source (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // eight serial lanes
    output logic      [63:0] lanes
);
    logic [4:0] cnt_q;
    // running count keeps stale words from matching
    always_ff @(posedge clk) cnt_q <= reset ? 5'h00 : cnt_q + 5'h01;
    // lane index in the low bits
    always_comb begin
        for (int x = 0; x < 8; x++) lanes[x*8 +: 8] = {cnt_q, 3'(x)};
    end
endmodule : serial_lane_source

// file: lane_sync_chk.sv
`timescale 1ns/1ps
// sync request, lane 6 and mask readback checks
module lane_sync_chk
    import lane_sync_pkg::*;
#(
    parameter int LANE_W = 8
) (
    // clock, reset, apb
    input wire logic clk, reset, psel, penable, pwrite, pready,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    // lanes, loss inputs, outputs
    input wire logic [LANES*LANE_W-1:0] physical_serial_input,
    input wire logic deframer0_frame_loss, deframer1_frame_loss,
    input wire logic deframer0_multiframe_loss, deframer1_multiframe_loss,
    input wire logic [LANE_W-1:0] logical_lane6,
    input wire logic sync_request_out0_n, sync_request_out1_n
);
    logic [3:0] m_q;
    logic [2:0] sel_q;
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic c0 = deframer0_frame_loss && m_q[0] || deframer0_multiframe_loss && m_q[2];
    wire logic c1 = deframer1_frame_loss && m_q[1] || deframer1_multiframe_loss && m_q[3];
    wire logic [LANE_W-1:0] sel_w = physical_serial_input[sel_q*LANE_W +: LANE_W];
    // shadow of mask and lane 6 select
    always_ff @(posedge clk) begin
        m_q <= reset ? 4'h0 : (wr && paddr == 14'hC44) ? pwdata[3:0] : m_q;
        sel_q <= reset ? 3'h6 : (wr && paddr == 14'hC2C) ? pwdata[2:0] : sel_q;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    frame0_out_a: assert property (deframer0_frame_loss && m_q[0] |=> !sync_request_out0_n)
        else $error("out0 missed frame loss");
    frame1_out_a: assert property (deframer1_frame_loss && m_q[1] |=> !sync_request_out1_n)
        else $error("out1 missed frame loss");
    mf0_out_a: assert property (deframer0_multiframe_loss && m_q[2] |=> !sync_request_out0_n)
        else $error("out0 missed multiframe loss");
    mf1_out_a: assert property (deframer1_multiframe_loss && m_q[3] |=> !sync_request_out1_n)
        else $error("out1 missed multiframe loss");
    idle0_out_a: assert property (!c0 |=> sync_request_out0_n)
        else $error("out0 low without enabled loss");
    idle1_out_a: assert property (!c1 |=> sync_request_out1_n)
        else $error("out1 low without enabled loss");
    lane6_mux_a: assert property (!$past(reset) |-> logical_lane6 == $past(sel_w))
        else $error("lane 6 word wrong");
    mask_read_a: assert property (pready && psel && !pwrite && paddr == 14'hC44 |-> prdata == {28'h0, m_q})
        else $error("mask readback wrong");
endmodule : lane_sync_chk
bind lane_fifo_status_sync_mask lane_sync_chk #(.LANE_W(LANE_W)) lane_sync_chk_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
    .physical_serial_input(physical_serial_input),
    .deframer0_frame_loss(deframer0_frame_loss), .deframer1_frame_loss(deframer1_frame_loss),
    .deframer0_multiframe_loss(deframer0_multiframe_loss),
    .deframer1_multiframe_loss(deframer1_multiframe_loss), .logical_lane6(logical_lane6),
    .sync_request_out0_n(sync_request_out0_n), .sync_request_out1_n(sync_request_out1_n));

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import lane_sync_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq, s0, s1, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, lv, mv;
    logic [63:0] lanes;
    logic [7:0]  full, empty, lane6;
    int          error_cnt, n_checks;

    lane_fifo_status_sync_mask lane_fifo_status_sync_mask_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .physical_serial_input(lanes), .lane_fifo_full(full),
        .lane_fifo_empty(empty), .deframer0_frame_loss(lv[0]), .deframer1_frame_loss(lv[1]),
        .deframer0_multiframe_loss(lv[2]), .deframer1_multiframe_loss(lv[3]),
        .logical_lane6(lane6), .sync_request_out0_n(s0), .sync_request_out1_n(s1), .irq(irq));
    serial_lane_source serial_lane_source_i (.clk(clk), .reset(reset), .lanes(lanes));

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    // one apb transfer; setup, then access until pready
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            error_cnt++;
            conclude();
        end
    endtask : apb
    task automatic rdc(input string nm, input logic [13:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    // 50 ns clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // main sequence
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'h1, 49'h0};
        pstrb = 4'hF;
        {lv, full, empty, error_cnt, n_checks} = '0;
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        rdc("full", 14'hC30, 32'h0);
        rdc("empty", 14'hC34, 32'h0);
        rdc("mask", 14'hC44, 32'h0);
        chk("lane6", 32'h6, {29'h0, lane6[2:0]});
        full <= 8'hA5;
        empty <= 8'h5A;
        repeat (6) @(posedge clk);
        rdc("full", 14'hC30, 32'hA5);
        rdc("empty", 14'hC34, 32'h5A);
        apb(1'h1, 14'hC30, 32'hFF);
        chk("err", 32'h0, {31'h0, er});
        rdc("full", 14'hC30, 32'hA5);
        apb(1'h1, 14'hC44, 32'hFF);
        rdc("mask", 14'hC44, 32'hF);
        // each enable bit against each loss input, then all off
        for (int m = 0; m < 5; m++) begin
            mv = 4'h1 << m;
            apb(1'h1, 14'hC44, {28'h0, mv});
            for (int j = 0; j < 4; j++) begin
                lv <= 4'h1 << j;
                repeat (2) @(posedge clk);
                chk("sync0", {31'h0, ~|(mv & lv & 4'h5)}, {31'h0, s0});
                chk("sync1", {31'h0, ~|(mv & lv & 4'hA)}, {31'h0, s1});
                lv <= 4'h0;
                repeat (2) @(posedge clk);
            end
        end
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'h1, 14'hC84, 32'hF);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("istat", 14'hC80, 32'hF);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        // a later event sets its status bit again, read clears it
        lv <= 4'h2;
        @(posedge clk);
        lv <= 4'h0;
        rdc("istat", 14'hC80, 32'h2);
        rdc("istat", 14'hC80, 32'h0);
        // every lane 6 source code
        for (int n = 0; n < 8; n++) begin
            apb(1'h1, 14'hC2C, 32'h38 | n);
            repeat (2) @(posedge clk);
            chk("lane6", n, {29'h0, lane6[2:0]});
        end
        rdc("xbar", 14'hC2C, 32'h3F);
        rdc("unmapped", 14'hC00, 32'h0);
        chk("err", 32'h1, {31'h0, er});
        conclude();
    end
endmodule : testbench
